// *** hbsd_map.svh ***
// Constants of the host bus strobe decoder
`ifndef HBSD_MAP_SVH
`define HBSD_MAP_SVH

// System clock period in ns (10 MHz)
`define HBSD_CLK_PERIOD_NS    100
// Edges from a pin change to the matching registered output
`define HBSD_DECODE_LATENCY   1
// Configuration value held while reset is asserted
`define HBSD_CFG_RST          3'h0
// Default variant options
`define HBSD_HAS_BYTE_HIGH    1'h1
`define HBSD_HAS_DATA_STROBE  1'h1

`endif

// *** hbsd_pkg.sv ***
// Types shared by the host bus strobe decoder
package hbsd_pkg;

  // Settings held in non-volatile configuration
  typedef struct packed {
    logic bus_width_select;        // 0: 8-bit with fetch strobe, 1: 16-bit with byte-high
    logic strobe_style_select;     // 0: separate strobes, 1: read-not-write direction
    logic strobe_polarity_select;  // 0: active-high enable, 1: active-low data strobe
  } hbsd_cfg_t;

  // Host control pins as sampled
  typedef struct packed {
    logic shared_n;   // program_fetch_strobe_n or byte_high_enable_n
    logic write_pin;  // write strobe (low) or direction (1 = read)
    logic rd_en_pin;  // read strobe, enable or data_strobe_n
  } hbsd_pins_t;

  typedef enum logic [2:0] {
    HBSD_NOP   = 3'b000,
    HBSD_FETCH = 3'b001,
    HBSD_READ  = 3'b010,
    HBSD_WRITE = 3'b011,
    HBSD_CLASH = 3'b100
  } hbsd_cycle_t;

endpackage : hbsd_pkg

// *** hbsd_cycle_decode.sv ***
// Combinational decode of host control pins into a cycle type
`timescale 1ns/1ps
`include "hbsd_map.svh"
module hbsd_cycle_decode
  import hbsd_pkg::*;
#(
  parameter bit HAS_BYTE_HIGH   = `HBSD_HAS_BYTE_HIGH,
  parameter bit HAS_DATA_STROBE = `HBSD_HAS_DATA_STROBE
) (
  // Settings and pins
  input  hbsd_cfg_t   i_cfg,
  input  hbsd_pins_t  i_pins,
  // Decoded cycle
  output hbsd_cycle_t o_cycle,
  output logic        o_upper
);

  logic wide;
  logic fetch;
  logic rd;
  logic wr;
  logic strobe;

  always_comb begin
    wide   = HAS_BYTE_HIGH && i_cfg.bus_width_select;
    fetch  = !wide && !i_pins.shared_n;
    strobe = 1'b0;
    if (!i_cfg.strobe_style_select) begin
      rd = !i_pins.rd_en_pin;
      wr = !i_pins.write_pin;
    end else begin
      // Reduced variant has no data strobe option, so polarity is ignored there
      strobe = (HAS_DATA_STROBE && i_cfg.strobe_polarity_select) ?
               !i_pins.rd_en_pin : i_pins.rd_en_pin;
      rd     = strobe && i_pins.write_pin;
      wr     = strobe && !i_pins.write_pin;
    end
    // Data read comes from the read/write pins only; an EPROM read comes from the fetch strobe alone
    if ((fetch && (rd || wr)) || (rd && wr)) begin
      o_cycle = HBSD_CLASH;
    end else if (fetch) begin
      o_cycle = HBSD_FETCH;
    end else if (rd) begin
      o_cycle = HBSD_READ;
    end else if (wr) begin
      o_cycle = HBSD_WRITE;
    end else begin
      o_cycle = HBSD_NOP;
    end
    o_upper = wide && !i_pins.shared_n && (rd ^ wr);
  end

endmodule : hbsd_cycle_decode

// *** hbsd_top.sv ***
// Host bus strobe decoder: turns host control pins into registered cycle strobes
`timescale 1ns/1ps
`include "hbsd_map.svh"
module hbsd_top
  import hbsd_pkg::*;
#(
  parameter bit HAS_BYTE_HIGH   = `HBSD_HAS_BYTE_HIGH,
  parameter bit HAS_DATA_STROBE = `HBSD_HAS_DATA_STROBE
) (
  // Clock and reset
  input  logic       I_CLK_SYS,
  input  logic       I_RST_N,
  // Host control pins
  input  logic       I_FETCH_OR_UPPER_N,
  input  logic       I_WRITE_OR_DIR,
  input  logic       I_READ_OR_STROBE,
  // Configuration settings
  input  logic       I_BUS_WIDTH_SELECT,
  input  logic       I_STROBE_STYLE_SELECT,
  input  logic       I_STROBE_POLARITY_SELECT,
  // Decoded cycle strobes
  output logic       O_FETCH_READ,
  output logic       O_DATA_READ,
  output logic       O_WRITE,
  output logic       O_NOP,
  output logic       O_UPPER_LANE,
  output logic       O_CLASH,
  output logic [2:0] O_CYCLE_TYPE,
  // Cycle events
  output logic       O_CYCLE_START,
  output logic       O_WRITE_COMMIT,
  output logic       O_CFG_VALID
);

  hbsd_cfg_t   cfg_q;
  hbsd_cfg_t   cfg_d;
  logic        cfg_valid_q;
  logic        cfg_valid_d;
  logic        valid_dly_q;
  logic        valid_dly_d;
  hbsd_pins_t  pins;
  hbsd_cycle_t dec_cycle;
  logic        dec_upper;
  hbsd_cycle_t cycle_q;
  hbsd_cycle_t cycle_d;
  logic        upper_q;
  logic        upper_d;
  logic        start_q;
  logic        start_d;
  logic        commit_q;
  logic        commit_d;

  assign pins.shared_n  = I_FETCH_OR_UPPER_N;
  assign pins.write_pin = I_WRITE_OR_DIR;
  assign pins.rd_en_pin = I_READ_OR_STROBE;

  hbsd_cycle_decode #(
    .HAS_BYTE_HIGH   (HAS_BYTE_HIGH),
    .HAS_DATA_STROBE (HAS_DATA_STROBE)
  ) u_decode (
    .i_cfg   (cfg_q),
    .i_pins  (pins),
    .o_cycle (dec_cycle),
    .o_upper (dec_upper)
  );

  // Settings are caught at the first edge after reset release, then frozen;
  // changing the pins later has no effect until the next reset
  always_comb begin
    cfg_d       = cfg_q;
    cfg_valid_d = 1'b1;
    valid_dly_d = cfg_valid_q;
    if (!cfg_valid_q) begin
      cfg_d.bus_width_select       = I_BUS_WIDTH_SELECT;
      cfg_d.strobe_style_select    = I_STROBE_STYLE_SELECT;
      cfg_d.strobe_polarity_select = I_STROBE_POLARITY_SELECT;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg_q       <= `HBSD_CFG_RST;
      cfg_valid_q <= 1'b0;
      valid_dly_q <= 1'b0;
    end else begin
      cfg_q       <= cfg_d;
      cfg_valid_q <= cfg_valid_d;
      valid_dly_q <= valid_dly_d;
    end
  end

  // No cycle is decoded until the settings are valid, so a stray strobe
  // during the capture edge cannot use the reset-time settings
  always_comb begin
    cycle_d  = cfg_valid_q ? dec_cycle : HBSD_NOP;
    upper_d  = cfg_valid_q && dec_upper;
    start_d  = (cycle_d != HBSD_NOP) && (cycle_d != HBSD_CLASH) && (cycle_d != cycle_q);
    commit_d = (cycle_q == HBSD_WRITE) && (cycle_d != HBSD_WRITE);
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cycle_q  <= HBSD_NOP;
      upper_q  <= 1'b0;
      start_q  <= 1'b0;
      commit_q <= 1'b0;
    end else begin
      cycle_q  <= cycle_d;
      upper_q  <= upper_d;
      start_q  <= start_d;
      commit_q <= commit_d;
    end
  end

  assign O_FETCH_READ   = (cycle_q == HBSD_FETCH);
  assign O_DATA_READ    = (cycle_q == HBSD_READ);
  assign O_WRITE        = (cycle_q == HBSD_WRITE);
  assign O_NOP          = (cycle_q == HBSD_NOP);
  assign O_CLASH        = (cycle_q == HBSD_CLASH);
  assign O_CYCLE_TYPE   = cycle_q;
  assign O_UPPER_LANE   = upper_q;
  assign O_CYCLE_START  = start_q;
  assign O_WRITE_COMMIT = commit_q;
  assign O_CFG_VALID    = cfg_valid_q;

  // Checks; those on the pins compare outputs with the pins sampled one edge earlier
  logic steady;
  logic wide;
  // Settings were already valid at the edge that registered the checked outputs
  assign steady = cfg_valid_q && valid_dly_q;
  assign wide   = HAS_BYTE_HIGH && cfg_q.bus_width_select;

  chk_fetch_8bit: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && !wide && !$past(I_FETCH_OR_UPPER_N) && !cfg_q.strobe_style_select
     && $past(I_READ_OR_STROBE) && $past(I_WRITE_OR_DIR)) |-> O_FETCH_READ)
    else $error("fetch strobe low in 8-bit mode did not give an EPROM read");

  chk_no_fetch_16: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wide |-> !O_FETCH_READ)
    else $error("fetch read reported in 16-bit mode");

  chk_read_source: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && O_DATA_READ) |->
      (cfg_q.strobe_style_select ? $past(I_WRITE_OR_DIR) : !$past(I_READ_OR_STROBE)))
    else $error("data read without the read pins calling for it");

  chk_read_no_fetch: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && !wide && !cfg_q.strobe_style_select && $past(I_FETCH_OR_UPPER_N)
     && !$past(I_READ_OR_STROBE) && $past(I_WRITE_OR_DIR)) |-> O_DATA_READ)
    else $error("read strobe with fetch held high did not read");

  chk_upper_lane: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && (O_DATA_READ || O_WRITE)) |->
      (O_UPPER_LANE == (wide && !$past(I_FETCH_OR_UPPER_N))))
    else $error("upper lane enable does not follow byte-high pin");

  chk_sep_write: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && !cfg_q.strobe_style_select) |->
      (O_WRITE == (!$past(I_WRITE_OR_DIR) && $past(I_READ_OR_STROBE)
                   && (wide || $past(I_FETCH_OR_UPPER_N)))))
    else $error("separate-strobe write does not follow write pin");

  chk_sep_read: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && !cfg_q.strobe_style_select && $past(I_WRITE_OR_DIR)
     && (wide || $past(I_FETCH_OR_UPPER_N))) |->
      (O_DATA_READ == !$past(I_READ_OR_STROBE)))
    else $error("separate-strobe read does not follow read pin");

  chk_enable_decode: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && cfg_q.strobe_style_select
     && (!HAS_DATA_STROBE || !cfg_q.strobe_polarity_select)
     && (wide || $past(I_FETCH_OR_UPPER_N))) |->
      (O_DATA_READ == ($past(I_READ_OR_STROBE) && $past(I_WRITE_OR_DIR)))
      && (O_WRITE == ($past(I_READ_OR_STROBE) && !$past(I_WRITE_OR_DIR))))
    else $error("enable-strobe decode wrong");

  chk_ds_decode: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && HAS_DATA_STROBE && cfg_q.strobe_style_select
     && cfg_q.strobe_polarity_select && (wide || $past(I_FETCH_OR_UPPER_N))) |->
      (O_DATA_READ == (!$past(I_READ_OR_STROBE) && $past(I_WRITE_OR_DIR)))
      && (O_WRITE == (!$past(I_READ_OR_STROBE) && !$past(I_WRITE_OR_DIR))))
    else $error("data-strobe decode wrong");

  chk_reduced_nods: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && !HAS_DATA_STROBE && cfg_q.strobe_style_select
     && !$past(I_READ_OR_STROBE)) |-> !O_DATA_READ && !O_WRITE)
    else $error("reduced variant treated strobe as active low");

  chk_cfg_frozen: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    $past(cfg_valid_q) |-> $stable(cfg_q) && cfg_valid_q)
    else $error("settings changed after capture");

  chk_commit_pulse: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    $fell(O_WRITE) |-> O_WRITE_COMMIT ##1 !O_WRITE_COMMIT)
    else $error("end of write did not give a one-cycle commit");

  chk_start_pulse: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (O_NOP ##1 (O_DATA_READ || O_WRITE || O_FETCH_READ)) |-> O_CYCLE_START)
    else $error("cycle start missing");

  chk_sep_clash: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && !cfg_q.strobe_style_select && !$past(I_WRITE_OR_DIR)
     && !$past(I_READ_OR_STROBE)) |-> O_CLASH)
    else $error("read and write strobes together did not give a clash");

  chk_fetch_clash: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && !wide && !$past(I_FETCH_OR_UPPER_N) && !cfg_q.strobe_style_select
     && !($past(I_READ_OR_STROBE) && $past(I_WRITE_OR_DIR))) |-> O_CLASH)
    else $error("fetch together with a data strobe did not give a clash");

  chk_enable_idle: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && cfg_q.strobe_style_select
     && (!HAS_DATA_STROBE || !cfg_q.strobe_polarity_select)
     && (wide || $past(I_FETCH_OR_UPPER_N)) && !$past(I_READ_OR_STROBE)) |-> O_NOP)
    else $error("enable low did not give a no-operation");

  chk_ds_idle: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (steady && HAS_DATA_STROBE && cfg_q.strobe_style_select && cfg_q.strobe_polarity_select
     && (wide || $past(I_FETCH_OR_UPPER_N)) && $past(I_READ_OR_STROBE)) |-> O_NOP)
    else $error("data strobe high did not give a no-operation");

  chk_upper_idle: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (O_NOP || O_FETCH_READ || O_CLASH) |-> !O_UPPER_LANE)
    else $error("upper lane enabled outside a read or write");

  chk_first_nop: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !$past(cfg_valid_q) |-> O_NOP)
    else $error("cycle decoded before the settings were captured");

  chk_commit_source: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_WRITE_COMMIT |-> $past(O_WRITE) && !O_WRITE)
    else $error("commit pulse without the end of a write");

  chk_start_change: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_CYCLE_START |-> !$stable(O_CYCLE_TYPE) && !O_NOP && !O_CLASH)
    else $error("cycle start without a new access type");

  cov_fetch: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_NOP ##1 O_FETCH_READ [*2] ##1 O_NOP);

  cov_upper_write: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_WRITE && O_UPPER_LANE ##1 O_WRITE_COMMIT);

  cov_ds_read: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    cfg_q.strobe_polarity_select && cfg_q.strobe_style_select && O_DATA_READ);

  cov_clash: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_CLASH);

endmodule : hbsd_top

// *** hbsd_host_model.sv ***
// Host-side model that turns a requested cycle into levels on the control pins
`timescale 1ns/1ps
module hbsd_host_model
  import hbsd_pkg::*;
(
  // Request from the bench
  input  wire hbsd_cfg_t   i_cfg,
  input  wire hbsd_cycle_t i_op,
  input  wire logic        i_upper,
  input  wire logic        i_noise,
  // Pins towards the device
  output      hbsd_pins_t  o_pins
);
  logic act;

  always_comb begin
    // Active level of the read/enable pin: low strobe unless enable style with polarity 0
    act = i_cfg.strobe_style_select & ~i_cfg.strobe_polarity_select;
    // Fetch stays high when no fetch is wanted; 16-bit reads and writes drive it as byte-high
    o_pins.shared_n  = 1'b1;
    // Direction carries junk while idle so a decoder that ignores the strobe is caught
    o_pins.write_pin = i_cfg.strobe_style_select ? i_noise : 1'b1;
    o_pins.rd_en_pin = ~act;
    case (i_op)
      HBSD_FETCH: begin
        o_pins.shared_n = 1'b0;
      end
      HBSD_READ: begin
        o_pins.shared_n  = i_cfg.bus_width_select ? ~i_upper : 1'b1;
        o_pins.write_pin = 1'b1;
        o_pins.rd_en_pin = act;
      end
      HBSD_WRITE: begin
        o_pins.shared_n  = i_cfg.bus_width_select ? ~i_upper : 1'b1;
        o_pins.write_pin = 1'b0;
        o_pins.rd_en_pin = i_cfg.strobe_style_select ? act : 1'b1;
      end
      HBSD_CLASH: begin
        if (!i_cfg.bus_width_select) begin
          o_pins.shared_n  = 1'b0;
          o_pins.write_pin = 1'b1;
          o_pins.rd_en_pin = act;
        end else begin
          o_pins.write_pin = 1'b0;
          o_pins.rd_en_pin = 1'b0;
        end
      end
      default: begin
      end
    endcase
  end
endmodule : hbsd_host_model

// *** hbsd_top_tb.sv ***
// Self-checking bench for the host bus strobe decoder
`timescale 1ns/1ps
module hbsd_top_tb;
  import hbsd_pkg::*;
  logic        clk, rst_n, upper, noise;
  logic        fetch_rd, data_rd, wr, nop, upper_ln, clash, start, commit, cfg_valid;
  logic [2:0]  ctype;
  logic [10:0] seen;
  logic [10:0] seen_r;
  logic [10:0] expv;
  logic        cfg_valid_r;
  logic [10:0] exp_q[$];
  logic [31:0] seed = 32'hcbe4d64b;
  logic [31:0] r;
  hbsd_cfg_t   cfg, cfg_pin;
  hbsd_cycle_t op, prev;
  hbsd_pins_t  pins;
  int          err_count = 0;
  int          comparisons = 0;

  assign seen = {ctype, fetch_rd, data_rd, wr, nop, clash, upper_ln, start, commit};

  hbsd_host_model host (.i_cfg(cfg), .i_op(op), .i_upper(upper), .i_noise(noise), .o_pins(pins));

  hbsd_top uut (
    .I_CLK_SYS(clk), .I_RST_N(rst_n),
    .I_FETCH_OR_UPPER_N(pins.shared_n), .I_WRITE_OR_DIR(pins.write_pin),
    .I_READ_OR_STROBE(pins.rd_en_pin),
    .I_BUS_WIDTH_SELECT(cfg_pin.bus_width_select),
    .I_STROBE_STYLE_SELECT(cfg_pin.strobe_style_select),
    .I_STROBE_POLARITY_SELECT(cfg_pin.strobe_polarity_select),
    .O_FETCH_READ(fetch_rd), .O_DATA_READ(data_rd), .O_WRITE(wr), .O_NOP(nop),
    .O_UPPER_LANE(upper_ln), .O_CLASH(clash), .O_CYCLE_TYPE(ctype),
    .O_CYCLE_START(start), .O_WRITE_COMMIT(commit), .O_CFG_VALID(cfg_valid)
  );

  // Reduced variant on the same pins: it has no data-strobe option
  hbsd_top #(.HAS_DATA_STROBE(1'b0)) uut_reduced (
    .I_CLK_SYS(clk), .I_RST_N(rst_n),
    .I_FETCH_OR_UPPER_N(pins.shared_n), .I_WRITE_OR_DIR(pins.write_pin),
    .I_READ_OR_STROBE(pins.rd_en_pin),
    .I_BUS_WIDTH_SELECT(cfg_pin.bus_width_select),
    .I_STROBE_STYLE_SELECT(cfg_pin.strobe_style_select),
    .I_STROBE_POLARITY_SELECT(cfg_pin.strobe_polarity_select),
    .O_FETCH_READ(seen_r[7]), .O_DATA_READ(seen_r[6]), .O_WRITE(seen_r[5]),
    .O_NOP(seen_r[4]), .O_UPPER_LANE(seen_r[2]), .O_CLASH(seen_r[3]),
    .O_CYCLE_TYPE(seen_r[10:8]), .O_CYCLE_START(seen_r[1]), .O_WRITE_COMMIT(seen_r[0]),
    .O_CFG_VALID(cfg_valid_r)
  );

  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand

  function automatic logic [10:0] expect_vec(hbsd_cycle_t c, hbsd_cycle_t p, logic up);
    logic rw;
    logic acc;
    rw  = (c == HBSD_READ) || (c == HBSD_WRITE);
    acc = rw || (c == HBSD_FETCH);
    return {c, c == HBSD_FETCH, c == HBSD_READ, c == HBSD_WRITE, c == HBSD_NOP,
            c == HBSD_CLASH, rw & up & cfg.bus_width_select, acc && (c != p),
            (p == HBSD_WRITE) && (c != HBSD_WRITE)};
  endfunction : expect_vec

  task automatic check(input string what, input logic [10:0] s, input logic [10:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, s);
    end
  endtask : check

  task automatic wrap_up();
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Results land one edge after the pins; look just after the edge settles
  initial begin
    forever begin
      @(posedge clk);
      #1;
      if (exp_q.size() > 0) begin
        expv = exp_q.pop_front();
        check("cycle outputs", seen, expv);
        // An active-low data strobe is beyond the reduced variant, so skip that setting
        if (!(cfg.strobe_style_select && cfg.strobe_polarity_select))
          check("reduced outputs", seen_r, expv);
      end
    end
  end

  // Eight settings of about 47 cycles each fit well inside this span
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    cfg = '0;
    cfg_pin = '0;
    op = HBSD_NOP;
    prev = HBSD_NOP;
    upper = 1'b0;
    noise = 1'b0;
    for (int k = 0; k < 8; k++) begin
      cfg = hbsd_cfg_t'(k[2:0]);
      cfg_pin = cfg;
      op = HBSD_NOP;
      prev = HBSD_NOP;
      rst_n = 1'b0;
      repeat (4) @(negedge clk);
      check("reset outputs", seen, {3'h0, 8'h10});
      check("reduced reset outputs", seen_r, {3'h0, 8'h10});
      check("settings valid", {9'h0, cfg_valid_r, cfg_valid}, 11'h0);
      rst_n = 1'b1;
      @(negedge clk);
      check("settings valid", {9'h0, cfg_valid_r, cfg_valid}, 11'h3);
      for (int i = 0; i < 40; i++) begin
        r = next_rand();
        op = hbsd_cycle_t'(r[2:0] % 3'h5);
        if (cfg.bus_width_select && op == HBSD_FETCH) op = HBSD_READ;
        if (cfg.bus_width_select && cfg.strobe_style_select && op == HBSD_CLASH) op = HBSD_WRITE;
        upper = r[3];
        noise = r[4];
        // Settings pins wander after capture; the decode must not follow them
        cfg_pin = hbsd_cfg_t'(r[7:5]);
        exp_q.push_back(expect_vec(op, prev, upper));
        prev = op;
        @(negedge clk);
      end
      op = HBSD_NOP;
      exp_q.push_back(expect_vec(HBSD_NOP, prev, 1'b0));
      prev = HBSD_NOP;
      repeat (2) @(negedge clk);
    end
    wrap_up();
  end
endmodule : hbsd_top_tb
